// File: hw/ssp_pkg.sv
// constants shared by the serial port design files
package ssp_pkg;
    localparam int unsigned clk_period_ns = 50;
    localparam int unsigned word_bits = 8;
    localparam int unsigned cnt_w = 3;
    localparam int unsigned div_w = 8;
    localparam logic [div_w-1:0] div_reset = 8'h04;
    localparam int unsigned buf_depth = 2;
    localparam logic [cnt_w-1:0] last_bit = 3'h7;
    typedef enum logic [1:0] {ssp_idle, ssp_lead, ssp_trail} ssp_state_t;
endpackage

// File: hw/ssp_buf.sv
// two-entry buffer with valid and ready on both sides
module ssp_buf (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import ssp_pkg::*;

    logic [7:0] mem_ff [buf_depth];
    logic wr_ptr_ff;
    logic rd_ptr_ff;
    logic [1:0] count_ff;
    logic push;
    logic pop;

    assign in_ready = (count_ff != 2'h2);
    assign out_valid = (count_ff != 2'h0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_ff[0] <= 8'h00;
            mem_ff[1] <= 8'h00;
        end else if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// File: hw/ssp_port.sv
// serial peripheral port: master or slave, four clock modes, multi-master error
// How it works
// R1 - four lines: data out, data in, clock, select
// R2 - master or slave, single or multi master
// R3 - slave acts only while external select asserted
// R4 - select stays an input in every mode
// R5 - select asserted while master raises error
// R6 - no select output; slaves chosen by gpio
// R7 - shift clock toggles only during transfer
// R8 - all four phase/polarity modes supported
// R9 - master drives clock, samples in, shifts out
// R10 - slave samples and drives only while selected
// R11 - error flag sticky; master stops driving lines
module ssp_port (
    clk,
    nrst,
    master_en,
    clk_pol,
    clk_pha,
    clk_div,
    tx_data,
    tx_valid,
    tx_ready,
    rx_data,
    rx_valid,
    rx_ready,
    busy,
    mm_error,
    mm_error_clr,
    master_out_line_i,
    master_out_line_o,
    master_out_line_oe,
    master_in_line_i,
    master_in_line_o,
    master_in_line_oe,
    shift_clock_i,
    shift_clock_o,
    shift_clock_oe,
    slave_select_in_n
);
    input wire logic clk;
    input wire logic nrst;
    input wire logic master_en;
    input wire logic clk_pol;
    input wire logic clk_pha;
    input wire logic [ssp_pkg::div_w-1:0] clk_div;
    input wire logic [7:0] tx_data;
    input wire logic tx_valid;
    output logic tx_ready;
    output logic [7:0] rx_data;
    output logic rx_valid;
    input wire logic rx_ready;
    output logic busy;
    output logic mm_error;
    input wire logic mm_error_clr;
    input wire logic master_out_line_i;
    output logic master_out_line_o;
    output logic master_out_line_oe;
    input wire logic master_in_line_i;
    output logic master_in_line_o;
    output logic master_in_line_oe;
    input wire logic shift_clock_i;
    output logic shift_clock_o;
    output logic shift_clock_oe;
    input wire logic slave_select_in_n;

    import ssp_pkg::*;

    // pins from outside pass two flops before use
    logic [1:0] sck_sync_ff;
    logic [1:0] sel_sync_ff;
    logic [1:0] mosi_sync_ff;
    logic [1:0] miso_sync_ff;
    logic sck_prev_ff;

    ssp_state_t state_ff;
    logic [cnt_w-1:0] bit_cnt_ff;
    logic [div_w-1:0] div_cnt_ff;
    logic [7:0] sh_ff;
    logic [7:0] rx_word_ff;
    logic rx_push_ff;
    logic sck_ff;
    logic out_bit_ff;
    logic err_ff;
    logic sel_prev_ff;

    logic sck_s;
    logic selected;
    logic rx_in_ready;
    logic tick;
    logic lead_edge;
    logic trail_edge;
    logic sample_edge;
    logic shift_edge;
    logic in_bit;
    logic slave_sample;
    logic slave_shift;

    // in phase 0 the leading edge samples; in phase 1 it shifts
    function automatic logic is_sample(input logic leading, input logic pha);
        return leading ^ pha;
    endfunction

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sck_sync_ff <= 2'b00;
            sel_sync_ff <= 2'b11;
            mosi_sync_ff <= 2'b00;
            miso_sync_ff <= 2'b00;
            sck_prev_ff <= 1'b0;
            sel_prev_ff <= 1'b0;
        end else begin
            sck_sync_ff <= {sck_sync_ff[0], shift_clock_i};
            sel_sync_ff <= {sel_sync_ff[0], slave_select_in_n};
            mosi_sync_ff <= {mosi_sync_ff[0], master_out_line_i};
            miso_sync_ff <= {miso_sync_ff[0], master_in_line_i};
            sck_prev_ff <= sck_sync_ff[1];
            sel_prev_ff <= selected;
        end
    end

    assign sck_s = sck_sync_ff[1];
    assign selected = ~sel_sync_ff[1]; // R4
    assign in_bit = master_en ? miso_sync_ff[1] : mosi_sync_ff[1]; // R1

    // master timing: one tick per half bit
    assign tick = (div_cnt_ff == '0);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt_ff <= div_reset;
        end else if (state_ff == ssp_idle || tick) begin
            div_cnt_ff <= clk_div;
        end else begin
            div_cnt_ff <= div_cnt_ff - 1'b1;
        end
    end

    // slave edges seen on the sampled link clock, relative to idle level
    assign lead_edge = (sck_s != sck_prev_ff) && (sck_s != clk_pol);
    assign trail_edge = (sck_s != sck_prev_ff) && (sck_s == clk_pol);
    assign slave_sample = selected && (is_sample(1'b1, clk_pha) ? lead_edge : trail_edge); // R10
    assign slave_shift = selected && (is_sample(1'b1, clk_pha) ? trail_edge : lead_edge); // R10

    always_comb begin
        sample_edge = 1'b0;
        shift_edge = 1'b0;
        if (master_en) begin
            sample_edge = tick && ((state_ff == ssp_lead && is_sample(1'b1, clk_pha))
                || (state_ff == ssp_trail && is_sample(1'b0, clk_pha))); // R9
            shift_edge = tick && ((state_ff == ssp_lead && !is_sample(1'b1, clk_pha))
                || (state_ff == ssp_trail && !is_sample(1'b0, clk_pha))); // R9
        end else begin
            sample_edge = slave_sample; // R3
            shift_edge = slave_shift;
        end
    end

    // a full receive buffer refuses new words; a reply still pending in rx_push_ff is not counted, so one can be lost
    assign tx_ready = (state_ff == ssp_idle) && !err_ff && (master_en || !selected) && rx_in_ready;

    // transfer sequencing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ssp_idle;
            bit_cnt_ff <= '0;
            sck_ff <= 1'b0;
        end else if (master_en && (selected || err_ff)) begin
            state_ff <= ssp_idle; // R11
            bit_cnt_ff <= '0;
            sck_ff <= clk_pol;
        end else begin
            unique case (state_ff)
                ssp_idle: begin
                    sck_ff <= clk_pol; // R8
                    bit_cnt_ff <= '0;
                    if (tx_valid && tx_ready) begin
                        state_ff <= ssp_lead;
                    end
                end
                ssp_lead: begin
                    if (master_en && tick) begin
                        sck_ff <= ~clk_pol; // R7
                        state_ff <= ssp_trail;
                    end else if (!master_en && lead_edge && selected) begin
                        state_ff <= ssp_trail;
                    end else if (!master_en && !selected && sel_prev_ff) begin
                        // armed slave waits for select; only a deselect aborts
                        state_ff <= ssp_idle;
                    end
                end
                ssp_trail: begin
                    if ((master_en && tick) || (!master_en && trail_edge && selected)) begin
                        sck_ff <= clk_pol;
                        bit_cnt_ff <= bit_cnt_ff + 1'b1;
                        state_ff <= (bit_cnt_ff == last_bit) ? ssp_idle : ssp_lead;
                    end else if (!master_en && !selected) begin
                        state_ff <= ssp_idle;
                    end
                end
            endcase
        end
    end

    // a slave word is loaded before select; an idle slave cannot arm while selected
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh_ff <= 8'h00;
            out_bit_ff <= 1'b0;
        end else if (state_ff == ssp_idle && tx_valid && tx_ready) begin
            sh_ff <= tx_data;
            out_bit_ff <= tx_data[7];
        end else if (sample_edge && state_ff != ssp_idle) begin
            sh_ff <= {sh_ff[6:0], in_bit};
        end else if (shift_edge && state_ff != ssp_idle) begin
            out_bit_ff <= sh_ff[7];
        end
    end

    // received word handed to the buffer on the last trailing edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_word_ff <= 8'h00;
            rx_push_ff <= 1'b0;
        end else begin
            rx_push_ff <= 1'b0;
            if (state_ff == ssp_trail && bit_cnt_ff == last_bit
                && ((master_en && tick && !selected) || (!master_en && trail_edge && selected))) begin
                // in phase 1 the last bit is sampled on this same edge
                rx_word_ff <= sample_edge ? {sh_ff[6:0], in_bit} : sh_ff;
                rx_push_ff <= 1'b1;
            end
        end
    end

    // sticky error; a new assertion wins over a clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            err_ff <= 1'b0;
        end else if (master_en && selected && !sel_prev_ff) begin
            err_ff <= 1'b1; // R5
        end else if (master_en && selected) begin
            err_ff <= 1'b1; // R11
        end else if (mm_error_clr) begin
            err_ff <= 1'b0;
        end
    end

    // rx_ready low fills the buffer; a full buffer drops nothing already held
    ssp_buf u_rx_buf (
        .clk(clk),
        .nrst(nrst),
        .in_data(rx_word_ff),
        .in_valid(rx_push_ff),
        .in_ready(rx_in_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    assign busy = (state_ff != ssp_idle) || !rx_in_ready;
    assign mm_error = err_ff;

    // no select output exists: external slaves use gpio pins
    assign shift_clock_o = sck_ff; // R6
    assign shift_clock_oe = master_en && !err_ff; // R9
    assign master_out_line_o = out_bit_ff;
    assign master_out_line_oe = master_en && !err_ff; // R11
    assign master_in_line_o = out_bit_ff;
    assign master_in_line_oe = !master_en && selected; // R10
endmodule

// File: dv/ssp_port_asserts.sv
// pin and stream checks for the serial port
module ssp_port_asserts (
    input wire logic clk,
    input wire logic nrst,
    input wire logic master_en,
    input wire logic clk_pol,
    input wire logic tx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic mm_error,
    input wire logic master_out_line_oe,
    input wire logic master_in_line_oe,
    input wire logic shift_clock_o,
    input wire logic shift_clock_oe,
    input wire logic slave_select_in_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_idle_level: assert property (
        master_en && tx_ready && $stable(clk_pol) && $stable(master_en) |-> shift_clock_o == clk_pol)
        else $error("shift clock not at idle level");
    // select passes two sync flops before it can set the flag
    chk_err_set: assert property ((master_en && !slave_select_in_n) [*4] |-> ##[0:1] mm_error)
        else $error("select in master mode gave no error");
    chk_err_win: assert property (master_en && mm_error && !slave_select_in_n |=> mm_error)
        else $error("error cleared while select held");
    chk_err_quiet: assert property (mm_error [*2] |-> !shift_clock_oe && !master_out_line_oe)
        else $error("lines driven during error");
    chk_err_refuse: assert property (mm_error |-> !tx_ready)
        else $error("word accepted during error");
    chk_slave_quiet: assert property ((!master_en && slave_select_in_n) [*4] |-> !master_in_line_oe)
        else $error("data in line driven while unselected");
    chk_master_miso: assert property (master_en [*2] |-> !master_in_line_oe)
        else $error("master drives its input line");
    chk_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("received word lost under stall");
    cover property (rx_valid && rx_ready);
    cover property ($rose(mm_error));
    cover property (!master_en && !slave_select_in_n && !tx_ready);
endmodule

// File: dv/ssp_slave_model.sv
// external serial slave, chosen by a general-purpose line
module ssp_slave_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    initial miso = 1'b0;
    always @(negedge sel_n) begin
        sh = reply;
        miso = reply[7];
    end
    // rotating keeps the reply repeating for back-to-back words
    always @(sclk) begin
        if (!sel_n && (sclk ^ cpol ^ cpha)) begin
            got = {got[6:0], mosi};
        end else if (!sel_n) begin
            if (!cpha) sh = {sh[6:0], sh[7]};
            miso = sh[7];
            if (cpha) sh = {sh[6:0], sh[7]};
        end
    end
    always @(posedge sel_n) miso = ~miso;
endmodule

// File: dv/test_ssp_port.sv
// testbench for the serial port with a slave model on its far side
module test_ssp_port;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0, master_en = 1'b1, clk_pol = 1'b0, clk_pha = 1'b0;
    logic tx_valid = 1'b0, rx_ready = 1'b0, mm_error_clr = 1'b0, slave_select_in_n = 1'b1;
    logic gpio_n = 1'b1, b_sclk = 1'b0, b_mosi = 1'b0;
    // input sync adds latency: a half bit needs at least four clocks
    logic [7:0] clk_div = 8'h03, tx_data = 8'h00, reply = 8'h00, got, rx_data;
    logic tx_ready, rx_valid, busy, mm_error, m_miso, master_out_line_o, master_out_line_oe;
    logic master_in_line_o, master_in_line_oe, shift_clock_o, shift_clock_oe;
    wire logic master_out_line_i = master_out_line_oe ? master_out_line_o : b_mosi;
    wire logic shift_clock_i = shift_clock_oe ? shift_clock_o : b_sclk;
    wire logic master_in_line_i = master_in_line_oe ? master_in_line_o : m_miso;
    int n_errors = 0, checks_done = 0;
    ssp_port ssp_port_i (.*);
    ssp_slave_model ssp_slave_model_i (.sclk(shift_clock_i), .mosi(master_out_line_i), .sel_n(gpio_n),
        .cpol(clk_pol), .cpha(clk_pha), .reply(reply), .miso(m_miso), .got(got));
    always #25 clk = ~clk;
    task chk(string what, logic [7:0] exp, logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task put(logic [7:0] d);
        tx_data = d;
        tx_valid = 1'b1;
        for (int i = 0; i < 500 && tx_ready !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        tx_valid = 1'b0;
    endtask
    task get(logic [7:0] e, string w);
        rx_ready = 1'b1;
        for (int i = 0; i < 500 && rx_valid !== 1'b1; i++) @(negedge clk);
        chk(w, e, rx_data);
        @(negedge clk);
        rx_ready = 1'b0;
    endtask
    task mxfer(logic [1:0] mode, logic [7:0] d, logic [7:0] r);
        {clk_pol, clk_pha} = mode;
        reply = r;
        @(negedge clk);
        gpio_n = 1'b0;
        put(d);
        get(r, "master rx");
        chk("slave got", d, got);
        chk("idle clock", 8'(shift_clock_o), 8'(mode[1]));
        gpio_n = 1'b1;
        @(negedge clk);
    endtask
    // receiver stalls while two words arrive back to back
    task fill;
        {clk_pol, clk_pha} = 2'b00;
        reply = 8'h5a;
        @(negedge clk);
        gpio_n = 1'b0;
        put(8'h11);
        put(8'h22);
        repeat (16 * 4 + 16) @(negedge clk);
        chk("full refuse", 8'(tx_ready), 8'h00);
        chk("busy full", 8'(busy), 8'h01);
        get(8'h5a, "rx first");
        get(8'h5a, "rx second");
        chk("second word", 8'h22, got);
        gpio_n = 1'b1;
    endtask
    task err;
        slave_select_in_n = 1'b0;
        repeat (6) @(negedge clk);
        chk("error", 8'(mm_error), 8'h01);
        chk("clock released", 8'(shift_clock_oe), 8'h00);
        chk("data released", 8'(master_out_line_oe), 8'h00);
        mm_error_clr = 1'b1;
        repeat (3) @(negedge clk);
        chk("error held", 8'(mm_error), 8'h01);
        slave_select_in_n = 1'b1;
        repeat (4) @(negedge clk);
        chk("error cleared", 8'(mm_error), 8'h00);
        mm_error_clr = 1'b0;
    endtask
    // bench is the master here; link edges stay 4 clocks apart
    task sxfer(logic [7:0] d, logic [7:0] t);
        logic [7:0] seen;
        master_en = 1'b0;
        {clk_pol, clk_pha} = 2'b00;
        @(negedge clk);
        put(t);
        slave_select_in_n = 1'b0;
        repeat (8) @(negedge clk);
        for (int i = 7; i >= 0; i--) begin
            b_mosi = d[i];
            #200 seen[i] = master_in_line_i;
            b_sclk = 1'b1;
            #200 b_sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        slave_select_in_n = 1'b1;
        b_mosi = ~b_mosi;
        get(d, "slave rx");
        chk("slave tx", t, seen);
        for (int i = 0; i < 8; i++) begin
            #200 b_sclk = 1'b1;
            #200 b_sclk = 1'b0;
        end
        chk("unselected rx", 8'(rx_valid), 8'h00);
        chk("unselected drive", 8'(master_in_line_oe), 8'h00);
        master_en = 1'b1;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        for (int m = 0; m < 4; m++) mxfer(2'(m), 8'h81 + 8'(m), 8'h3c - 8'(m));
        fill();
        err();
        sxfer(8'h6b, 8'hc3);
        test_done();
    end
    initial begin
        #250000;
        n_errors++;
        test_done();
    end
endmodule
bind ssp_port ssp_port_asserts ssp_port_asserts_i (.*);
